// File: hw/dspdec_params.svh
// Summary of operation
// - Single-word instruction is 24 bits, 8-bit opcode.
// - Exactly three instructions take two words.
// - True condition or PC change adds cycle.
// - Branch, indirect, table, returns take 2-3 cycles.
// - Taken skip takes two or three cycles, untaken skip one.
// - Double-word instructions complete in two cycles.
// - File result goes to register or working_reg_zero.
// - Three-operand form decodes base, second, destination.
// - Bit number from literal or base register.
// - Separate destination only when differing from source.
// - MAC decodes accumulator, operands, prefetch, write-back.
// - Write-back limited to W13 or [W13]+=2.
// - Bit select field is 4 bits, 0-15.
// - File address spans 0x0000 to 0x1FFF.
// - Ten-bit literal 0-255 byte, 0-1023 word.
// - Program address literal has LSB zero.
// - Signed ten-bit literal spans -512 to 511.
// - Processor and DSP status flag groups kept.
`ifndef DSPDEC_PARAMS_SVH
`define DSPDEC_PARAMS_SVH

// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define DSPDEC_CTRL_ADDR 12'h000
`define DSPDEC_FLAGS_ADDR 12'h004
`define DSPDEC_STATUS_ADDR 12'h008
`define DSPDEC_COUNT_ADDR 12'h00C
`define DSPDEC_CTRL_RST 1'h1
`define DSPDEC_FLAG_DSP_LSB 8

// ****************************************************************
// Opcodes
// ****************************************************************
`define DSPDEC_OP_NOP 8'h00
`define DSPDEC_OP_IND 8'h01
`define DSPDEC_OP_CALL_L 8'h02
`define DSPDEC_OP_GOTO_L 8'h04
`define DSPDEC_OP_RET 8'h06
`define DSPDEC_OP_DO_L 8'h08
`define DSPDEC_OP_BRA 8'h37
`define DSPDEC_OP_BCOND_HI 4'h3
`define DSPDEC_OP_W3 8'h40
`define DSPDEC_OP_LITAR 8'h41
`define DSPDEC_OP_SLIT 8'h90
`define DSPDEC_OP_BIT_LIT 8'hA0
`define DSPDEC_OP_BIT_IND 8'hA1
`define DSPDEC_OP_SKIP 8'hA6
`define DSPDEC_OP_LIT 8'hB0
`define DSPDEC_OP_FILE 8'hB4
`define DSPDEC_OP_TBLRD 8'hBA
`define DSPDEC_OP_TBLWR 8'hBB
`define DSPDEC_OP_MOVD 8'hBE
`define DSPDEC_OP_MAC_HI 6'h30

// ****************************************************************
// Extra cycles beyond the first, and the invalid write-back code
// ****************************************************************
`define DSPDEC_EXTRA_BRANCH 2'h1
`define DSPDEC_EXTRA_TABLE 2'h1
`define DSPDEC_EXTRA_RETURN 2'h2
`define DSPDEC_EXTRA_MOVD 2'h1
`define DSPDEC_AWB_BAD 2'h3

`endif

// File: hw/dspdec_pkg.sv
package dspdec_pkg;

  typedef enum logic [2:0] {
    DSPDEC_S_IDLE = 3'b000,
    DSPDEC_S_SECOND = 3'b001,
    DSPDEC_S_NOP = 3'b010,
    DSPDEC_S_FLUSH = 3'b011,
    DSPDEC_S_FLUSH2 = 3'b100
  } dspdec_state_t;

  typedef struct packed {
    dspdec_state_t state;
    logic [1:0] cnt;
    logic enable;
    logic [4:0] proc_flags;
    logic [3:0] dsp_flags;
    logic [15:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fetch_stall;
    logic insert_nop;
    logic dec_valid;
    logic double_word;
    logic [7:0] opcode;
    logic byte_mode;
    logic [3:0] base_source_reg;
    logic [3:0] second_source_reg;
    logic [2:0] second_source_mode;
    logic [3:0] dest_reg;
    logic [2:0] dest_mode;
    logic lit_dest_separate;
    logic [12:0] file_addr;
    logic dest_is_working_reg_zero;
    logic [3:0] bit_select_field;
    logic bit_from_base_reg;
    logic [9:0] unsigned_literal_ten;
    logic lit_range_err;
    logic [15:0] signed_literal_ten;
    logic [22:0] unsigned_literal_twentythree;
    logic accum_sel;
    logic [2:0] mult_pair;
    logic [3:0] x_prefetch;
    logic [1:0] x_dest;
    logic [3:0] y_prefetch;
    logic [1:0] y_dest;
    logic [1:0] accum_writeback_dest;
    logic upd_proc_flags;
    logic upd_dsp_flags;
  } dspdec_regs_t;

endpackage : dspdec_pkg

// File: hw/dspdec_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspdec_params.svh"

module dspdec_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic cond_true,
  input wire logic proc_flag_we,
  input wire logic [4:0] proc_flag_in,
  input wire logic dsp_flag_we,
  input wire logic [3:0] dsp_flag_in,
  output logic fetch_stall,
  output logic insert_nop,
  output logic dec_valid,
  output logic double_word,
  output logic [7:0] opcode,
  output logic byte_mode,
  output logic [3:0] base_source_reg,
  output logic [3:0] second_source_reg,
  output logic [2:0] second_source_mode,
  output logic [3:0] dest_reg,
  output logic [2:0] dest_mode,
  output logic lit_dest_separate,
  output logic [12:0] file_addr,
  output logic dest_is_working_reg_zero,
  output logic [3:0] bit_select_field,
  output logic bit_from_base_reg,
  output logic [9:0] unsigned_literal_ten,
  output logic lit_range_err,
  output logic [15:0] signed_literal_ten,
  output logic [22:0] unsigned_literal_twentythree,
  output logic accum_sel,
  output logic [2:0] mult_pair,
  output logic [3:0] x_prefetch,
  output logic [1:0] x_dest,
  output logic [3:0] y_prefetch,
  output logic [1:0] y_dest,
  output logic [1:0] accum_writeback_dest,
  output logic upd_proc_flags,
  output logic upd_dsp_flags,
  output logic [4:0] proc_flags,
  output logic [3:0] dsp_flags
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic dspdec_is_double(input logic [7:0] op);
    dspdec_is_double = (op == `DSPDEC_OP_CALL_L) || (op == `DSPDEC_OP_GOTO_L) ||
                       (op == `DSPDEC_OP_DO_L);
  endfunction : dspdec_is_double

  function automatic logic [1:0] dspdec_extra(input logic [7:0] op, input logic c);
    dspdec_extra = 2'h0;
    if ((op == `DSPDEC_OP_BRA) || (op == `DSPDEC_OP_IND))
      dspdec_extra = `DSPDEC_EXTRA_BRANCH;
    else if ((op == `DSPDEC_OP_TBLRD) || (op == `DSPDEC_OP_TBLWR))
      dspdec_extra = `DSPDEC_EXTRA_TABLE;
    else if (op == `DSPDEC_OP_RET)
      dspdec_extra = `DSPDEC_EXTRA_RETURN;
    else if (op == `DSPDEC_OP_MOVD)
      dspdec_extra = `DSPDEC_EXTRA_MOVD;
    else if ((op[7:4] == `DSPDEC_OP_BCOND_HI) && c)
      dspdec_extra = `DSPDEC_EXTRA_BRANCH;
  endfunction : dspdec_extra

  dspdec_pkg::dspdec_regs_t s;
  dspdec_pkg::dspdec_regs_t next_s;
  logic [7:0] op;
  logic [23:0] w;
  logic [1:0] extra;

  assign w = instr_word;
  assign op = s.enable ? instr_word[23:16] : `DSPDEC_OP_NOP;
  assign extra = dspdec_extra(op, cond_true);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    next_s = s;
    next_s.dec_valid = 1'b0;
    next_s.insert_nop = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    // Answer is prepared in the setup cycle so the access phase has no wait.
    if (psel && !penable)
    begin
      next_s.pready = 1'b1;
      unique case (paddr)
        `DSPDEC_CTRL_ADDR: next_s.prdata = {31'h0, s.enable};
        `DSPDEC_FLAGS_ADDR: next_s.prdata = {20'h0, s.dsp_flags, 3'h0, s.proc_flags};
        `DSPDEC_STATUS_ADDR: next_s.prdata = {20'h0, s.fetch_stall, s.state, s.opcode};
        `DSPDEC_COUNT_ADDR: next_s.prdata = {16'h0, s.count};
        default:
        begin
          next_s.prdata = 32'h0;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && s.pready && pwrite)
    begin
      if (paddr == `DSPDEC_CTRL_ADDR)
        next_s.enable = pwdata[0];
      if (paddr == `DSPDEC_FLAGS_ADDR)
      begin
        next_s.proc_flags = pwdata[4:0];
        next_s.dsp_flags = pwdata[`DSPDEC_FLAG_DSP_LSB +: 4];
      end
    end
    // Execution updates win over a software write in the same cycle.
    if (proc_flag_we)
      next_s.proc_flags = proc_flag_in;
    if (dsp_flag_we)
      next_s.dsp_flags = dsp_flag_in;
    unique case (s.state)
      dspdec_pkg::DSPDEC_S_IDLE:
      begin
        if (instr_valid)
        begin
          next_s.dec_valid = 1'b1;
          next_s.double_word = 1'b0;
          next_s.count = s.count + 16'h1;
          next_s.opcode = op;
          next_s.byte_mode = w[14];
          next_s.base_source_reg = w[18:15];
          next_s.dest_mode = w[13:11];
          next_s.dest_reg = w[10:7];
          next_s.second_source_mode = w[6:4];
          next_s.second_source_reg = w[3:0];
          next_s.lit_dest_separate = 1'b0;
          if (op == `DSPDEC_OP_LITAR)
          begin
            next_s.lit_dest_separate = (w[10:7] != w[18:15]);
            if (w[10:7] == w[18:15])
              next_s.dest_reg = w[18:15];
          end
          next_s.file_addr = w[12:0];
          next_s.dest_is_working_reg_zero = (op == `DSPDEC_OP_FILE) && !w[13];
          next_s.bit_select_field = w[15:12];
          next_s.bit_from_base_reg = (op == `DSPDEC_OP_BIT_IND);
          next_s.unsigned_literal_ten = w[13:4];
          next_s.lit_range_err = 1'b0;
          if ((op == `DSPDEC_OP_LIT) && w[14])
          begin
            // Byte mode keeps only the low eight bits and reports the excess.
            next_s.unsigned_literal_ten = {2'h0, w[11:4]};
            next_s.lit_range_err = |w[13:12];
          end
          next_s.signed_literal_ten = {{6{w[13]}}, w[13:4]};
          next_s.accum_sel = w[15];
          next_s.mult_pair = w[14:12];
          next_s.x_prefetch = w[11:8];
          next_s.x_dest = w[7:6];
          next_s.y_prefetch = w[5:2];
          next_s.y_dest = w[1:0];
          next_s.accum_writeback_dest = (w[17:16] == `DSPDEC_AWB_BAD) ? 2'h0 : w[17:16];
          next_s.upd_dsp_flags = (op[7:2] == `DSPDEC_OP_MAC_HI);
          next_s.upd_proc_flags = (op == `DSPDEC_OP_FILE) || (op == `DSPDEC_OP_W3) ||
                                  (op == `DSPDEC_OP_LIT) || (op == `DSPDEC_OP_LITAR);
          next_s.unsigned_literal_twentythree = {7'h0, w[15:1], 1'b0};
          if (dspdec_is_double(op))
            next_s.state = dspdec_pkg::DSPDEC_S_SECOND;
          else if ((op == `DSPDEC_OP_SKIP) && cond_true)
            next_s.state = dspdec_pkg::DSPDEC_S_FLUSH;
          else if (extra != 2'h0)
          begin
            next_s.state = dspdec_pkg::DSPDEC_S_NOP;
            next_s.cnt = extra;
            next_s.fetch_stall = 1'b1;
          end
        end
      end
      dspdec_pkg::DSPDEC_S_SECOND:
      begin
        // The second word is part of the instruction, not a separate one.
        if (instr_valid)
        begin
          next_s.double_word = 1'b1;
          next_s.unsigned_literal_twentythree[22:16] = w[6:0];
          next_s.state = dspdec_pkg::DSPDEC_S_IDLE;
        end
      end
      dspdec_pkg::DSPDEC_S_NOP:
      begin
        next_s.insert_nop = 1'b1;
        next_s.cnt = s.cnt - 2'h1;
        if (s.cnt == 2'h1)
        begin
          next_s.state = dspdec_pkg::DSPDEC_S_IDLE;
          next_s.fetch_stall = 1'b0;
        end
      end
      dspdec_pkg::DSPDEC_S_FLUSH:
      begin
        // A skipped double-word instruction costs one more flushed word.
        if (instr_valid)
        begin
          next_s.insert_nop = 1'b1;
          next_s.state = dspdec_is_double(op) ? dspdec_pkg::DSPDEC_S_FLUSH2 :
                                                 dspdec_pkg::DSPDEC_S_IDLE;
        end
      end
      dspdec_pkg::DSPDEC_S_FLUSH2:
      begin
        if (instr_valid)
        begin
          next_s.insert_nop = 1'b1;
          next_s.state = dspdec_pkg::DSPDEC_S_IDLE;
        end
      end
      default:
        next_s.state = dspdec_pkg::DSPDEC_S_IDLE;
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.enable <= `DSPDEC_CTRL_RST;
    end
    else
      s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign fetch_stall = s.fetch_stall;
  assign insert_nop = s.insert_nop;
  assign dec_valid = s.dec_valid;
  assign double_word = s.double_word;
  assign opcode = s.opcode;
  assign byte_mode = s.byte_mode;
  assign base_source_reg = s.base_source_reg;
  assign second_source_reg = s.second_source_reg;
  assign second_source_mode = s.second_source_mode;
  assign dest_reg = s.dest_reg;
  assign dest_mode = s.dest_mode;
  assign lit_dest_separate = s.lit_dest_separate;
  assign file_addr = s.file_addr;
  assign dest_is_working_reg_zero = s.dest_is_working_reg_zero;
  assign bit_select_field = s.bit_select_field;
  assign bit_from_base_reg = s.bit_from_base_reg;
  assign unsigned_literal_ten = s.unsigned_literal_ten;
  assign lit_range_err = s.lit_range_err;
  assign signed_literal_ten = s.signed_literal_ten;
  assign unsigned_literal_twentythree = s.unsigned_literal_twentythree;
  assign accum_sel = s.accum_sel;
  assign mult_pair = s.mult_pair;
  assign x_prefetch = s.x_prefetch;
  assign x_dest = s.x_dest;
  assign y_prefetch = s.y_prefetch;
  assign y_dest = s.y_dest;
  assign accum_writeback_dest = s.accum_writeback_dest;
  assign upd_proc_flags = s.upd_proc_flags;
  assign upd_dsp_flags = s.upd_dsp_flags;
  assign proc_flags = s.proc_flags;
  assign dsp_flags = s.dsp_flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic idle_take;
  assign idle_take = (s.state == dspdec_pkg::DSPDEC_S_IDLE) && instr_valid;

  branch_two_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      idle_take && (op == `DSPDEC_OP_BRA) |=> fetch_stall ##1 (!fetch_stall && insert_nop))
    else $error("branch did not take two cycles");
  return_three_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      idle_take && (op == `DSPDEC_OP_RET) |=> fetch_stall [*2] ##1 !fetch_stall)
    else $error("return did not take three cycles");
  cond_false_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      idle_take && (op[7:4] == `DSPDEC_OP_BCOND_HI) && (op != `DSPDEC_OP_BRA) && !cond_true
      |=> !fetch_stall && (s.state == dspdec_pkg::DSPDEC_S_IDLE))
    else $error("untaken branch stalled");
  double_two_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      idle_take && dspdec_is_double(op) |=> (s.state == dspdec_pkg::DSPDEC_S_SECOND) && !fetch_stall)
    else $error("double-word instruction not waiting for second word");
  skip_flush_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      idle_take && (op == `DSPDEC_OP_SKIP) && cond_true
      |=> (s.state == dspdec_pkg::DSPDEC_S_FLUSH))
    else $error("taken skip did not flush");
  lone_second_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      idle_take && (w[23:16] == 8'h00) |=> dec_valid && (opcode == 8'h00) && !fetch_stall)
    else $error("lone second word not a no-operation");
  lsb_zero_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      !unsigned_literal_twentythree[0])
    else $error("program address literal odd");
  byte_lit_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      dec_valid && byte_mode && (opcode == `DSPDEC_OP_LIT) |-> (unsigned_literal_ten[9:8] == 2'h0))
    else $error("byte literal above 255");
  sign_ext_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      dec_valid |-> (signed_literal_ten[15:10] == {6{signed_literal_ten[9]}}))
    else $error("signed literal not sign extended");
  awb_limit_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      accum_writeback_dest != `DSPDEC_AWB_BAD)
    else $error("write-back destination out of range");
  nop_stall_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s.state == dspdec_pkg::DSPDEC_S_NOP) |-> fetch_stall)
    else $error("fetch not stalled during inserted cycles");

endmodule : dspdec_core
`default_nettype wire

// File: sim/dspdec_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Program memory fetch path
// ****************************************************************
module dspdec_fetch_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [3:0] len,
  input wire logic [23:0] prog [0:7],
  input wire logic fetch_stall,
  output logic instr_valid,
  output logic [23:0] instr_word,
  output logic done
);
  logic [3:0] idx;
  logic [23:0] last;

  // Past the program the bus is released, so it shows the inverse of the last word.
  // The start cycle shows nothing, so a stale index never meets a longer new program.
  assign instr_valid = !start && (idx < len);
  assign instr_word = instr_valid ? prog[idx[2:0]] : ~last;
  assign done = !instr_valid;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx <= 4'hF;
      last <= 24'h000000;
    end
    else if (start)
      idx <= 4'h0;
    else if (instr_valid && !fetch_stall)
    begin
      idx <= idx + 4'h1;
      last <= instr_word;
    end
  end
endmodule : dspdec_fetch_model

`default_nettype wire

// File: sim/dsp_controller_instr_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspdec_params.svh"

module dsp_controller_instr_decode_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic cond_true = 1'b0, proc_flag_we = 1'b0, dsp_flag_we = 1'b0, start = 1'b0;
  logic [4:0] proc_flag_in = 5'h00;
  logic [3:0] dsp_flag_in = 4'h0, len = 4'h0;
  logic [23:0] prog [0:7] = '{default: 24'h000000};
  logic [23:0] instr_word;
  logic [31:0] prdata, r;
  logic pready, pslverr, fetch_stall, insert_nop, dec_valid, double_word, byte_mode, e;
  logic lit_dest_separate, dest_is_working_reg_zero, bit_from_base_reg, lit_range_err;
  logic accum_sel, upd_proc_flags, upd_dsp_flags, instr_valid, done;
  logic [7:0] opcode;
  logic [3:0] base_source_reg, second_source_reg, dest_reg, bit_select_field;
  logic [3:0] x_prefetch, y_prefetch, dsp_flags;
  logic [2:0] second_source_mode, dest_mode, mult_pair;
  logic [12:0] file_addr;
  logic [9:0] unsigned_literal_ten;
  logic [15:0] signed_literal_ten;
  logic [22:0] unsigned_literal_twentythree;
  logic [1:0] x_dest, y_dest, accum_writeback_dest;
  logic [4:0] proc_flags;
  int nop_cnt = 0, dv_cnt = 0, dw_cnt = 0, st_cnt = 0, cyc = 0;
  int failures = 0, compares = 0, d_nop, d_dv, d_dw, d_st;
  logic [7:0] ops [0:8] = '{`DSPDEC_OP_BRA, `DSPDEC_OP_IND, `DSPDEC_OP_TBLRD, `DSPDEC_OP_TBLWR,
    `DSPDEC_OP_RET, `DSPDEC_OP_MOVD, 8'h3A, 8'h3A, `DSPDEC_OP_FILE};
  logic cnd [0:8] = '{0, 0, 0, 0, 0, 0, 1, 0, 0};
  int nops [0:8] = '{1, 1, 1, 1, 2, 1, 1, 0, 0};
  logic [7:0] dws [0:2] = '{`DSPDEC_OP_CALL_L, `DSPDEC_OP_GOTO_L, `DSPDEC_OP_DO_L};

  dspdec_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_valid, .instr_word, .cond_true, .proc_flag_we, .proc_flag_in,
    .dsp_flag_we, .dsp_flag_in, .fetch_stall, .insert_nop, .dec_valid, .double_word, .opcode,
    .byte_mode, .base_source_reg, .second_source_reg, .second_source_mode, .dest_reg,
    .dest_mode, .lit_dest_separate, .file_addr, .dest_is_working_reg_zero, .bit_select_field,
    .bit_from_base_reg, .unsigned_literal_ten, .lit_range_err, .signed_literal_ten,
    .unsigned_literal_twentythree, .accum_sel, .mult_pair, .x_prefetch, .x_dest, .y_prefetch,
    .y_dest, .accum_writeback_dest, .upd_proc_flags, .upd_dsp_flags, .proc_flags, .dsp_flags);

  dspdec_fetch_model u_mem (.pclk, .presetn, .start, .len, .prog, .fetch_stall, .instr_valid,
    .instr_word, .done);

  // ****************************************************************
  // Clock, pulse counters and hang guard
  // ****************************************************************
  always #25 pclk = ~pclk;

  always @(posedge pclk)
  begin
    nop_cnt <= nop_cnt + int'(insert_nop === 1'b1);
    dv_cnt <= dv_cnt + int'(dec_valid === 1'b1);
    dw_cnt <= dw_cnt + int'(double_word === 1'b1);
    st_cnt <= st_cnt + int'(fetch_stall === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      summarize();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h00000000);
    chk(r, exp, "read data");
    chk(e, err, "slave error");
  endtask : rd

  task automatic run(input logic [23:0] w0, input logic [23:0] w1, input logic [3:0] n,
                     input logic c);
    int b_nop;
    int b_dv;
    int b_dw;
    int b_st;
    @(posedge pclk);
    b_nop = nop_cnt;
    b_dv = dv_cnt;
    b_dw = dw_cnt;
    b_st = st_cnt;
    prog[0] <= w0;
    prog[1] <= w1;
    prog[2] <= 24'h000000;
    len <= n;
    cond_true <= c;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge pclk);
    while (!(done === 1'b1 && fetch_stall === 1'b0))
      @(posedge pclk);
    repeat (4) @(posedge pclk);
    d_nop = nop_cnt - b_nop;
    d_dv = dv_cnt - b_dv;
    d_dw = dw_cnt - b_dw;
    d_st = st_cnt - b_st;
  endtask : run

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DSPDEC_CTRL_ADDR, 32'h00000001, 1'b0);
    rd(`DSPDEC_FLAGS_ADDR, 32'h00000000, 1'b0);
    rd(12'h010, 32'h00000000, 1'b1);
    rd(`DSPDEC_COUNT_ADDR, 32'h00000000, 1'b0);
    apb(1'b1, `DSPDEC_STATUS_ADDR, 32'hFFFFFFFF);
    rd(`DSPDEC_STATUS_ADDR, 32'h00000000, 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      run({ops[i], 16'h0000}, 24'h000000, 4'h1, cnd[i]);
      chk(d_nop, nops[i], "inserted cycles");
      chk(d_st, nops[i], "stall cycles");
      chk(d_dv, 1, "decodes");
    end
    for (int i = 0; i < 3; i++)
    begin
      run({dws[i], 16'hABCD}, 24'h000055, 4'h2, 1'b0);
      chk(unsigned_literal_twentythree, {7'h55, 15'h55E6, 1'b0}, "long literal");
      chk({d_dv, d_nop}, {32'd1, 32'd0}, "double word timing");
      chk({double_word, d_dw != 0}, 2'b11, "second word taken");
    end
    run(24'h000123, 24'h000000, 4'h1, 1'b0);
    chk({opcode, upd_proc_flags, 32'(d_nop)}, 0, "lone second word");
    run({`DSPDEC_OP_SKIP, 16'h0000}, {`DSPDEC_OP_FILE, 16'h0000}, 4'h2, 1'b1);
    chk({d_dv, d_nop}, {32'd1, 32'd1}, "skip one word");
    run({`DSPDEC_OP_SKIP, 16'h0000}, {`DSPDEC_OP_CALL_L, 16'h0000}, 4'h3, 1'b1);
    chk({d_dv, d_nop}, {32'd1, 32'd2}, "skip two words");
    run({`DSPDEC_OP_SKIP, 16'h0000}, {`DSPDEC_OP_FILE, 16'h0000}, 4'h2, 1'b0);
    chk({d_dv, d_nop}, {32'd2, 32'd0}, "no skip");
    run({`DSPDEC_OP_FILE, 16'h1FFF}, 24'h000000, 4'h1, 1'b0);
    chk({file_addr, dest_is_working_reg_zero, upd_proc_flags}, {13'h1FFF, 2'b11}, "file");
    run({`DSPDEC_OP_FILE, 16'h3FFF}, 24'h000000, 4'h1, 1'b0);
    chk(dest_is_working_reg_zero, 1'b0, "file to register");
    run({`DSPDEC_OP_LITAR, 16'h8180}, 24'h000000, 4'h1, 1'b0);
    chk({lit_dest_separate, dest_reg}, 5'h03, "same destination");
    run({`DSPDEC_OP_LITAR, 16'h8280}, 24'h000000, 4'h1, 1'b0);
    chk({lit_dest_separate, dest_reg}, 5'h15, "separate destination");
    run({`DSPDEC_OP_W3, 16'hB5A7}, 24'h000000, 4'h1, 1'b0);
    chk({base_source_reg, dest_mode, dest_reg, second_source_mode, second_source_reg},
        {4'h1, 3'h6, 4'hB, 3'h2, 4'h7}, "three operands");
    run({`DSPDEC_OP_BIT_LIT, 16'hF000}, 24'h000000, 4'h1, 1'b0);
    chk({bit_select_field, bit_from_base_reg}, 5'h1E, "bit literal");
    run({`DSPDEC_OP_BIT_IND, 16'h0000}, 24'h000000, 4'h1, 1'b0);
    chk(bit_from_base_reg, 1'b1, "bit from register");
    run({`DSPDEC_OP_LIT, 16'h7FF0}, 24'h000000, 4'h1, 1'b0);
    chk({unsigned_literal_ten, lit_range_err, byte_mode}, {10'h0FF, 2'b11}, "byte literal");
    run({`DSPDEC_OP_LIT, 16'h3FF0}, 24'h000000, 4'h1, 1'b0);
    chk({unsigned_literal_ten, lit_range_err, byte_mode}, {10'h3FF, 2'b00}, "word literal");
    run({`DSPDEC_OP_SLIT, 16'h2000}, 24'h000000, 4'h1, 1'b0);
    chk(signed_literal_ten, 16'hFE00, "signed minimum");
    run({`DSPDEC_OP_SLIT, 16'h1FF0}, 24'h000000, 4'h1, 1'b0);
    chk(signed_literal_ten, 16'h01FF, "signed maximum");
    for (int i = 1; i < 4; i++)
    begin
      run({6'h30, 2'(i), 16'hD5A6}, 24'h000000, 4'h1, 1'b0);
      chk(accum_writeback_dest, (i == 3) ? 2'h0 : 2'(i), "write-back");
      chk({accum_sel, mult_pair, x_prefetch, x_dest, y_prefetch, y_dest, upd_dsp_flags},
          {16'hD5A6, 1'b1}, "multiply fields");
    end
    @(posedge pclk);
    proc_flag_we <= 1'b1;
    proc_flag_in <= 5'h15;
    dsp_flag_we <= 1'b1;
    dsp_flag_in <= 4'hA;
    @(posedge pclk);
    proc_flag_we <= 1'b0;
    dsp_flag_we <= 1'b0;
    rd(`DSPDEC_FLAGS_ADDR, 32'h00000A15, 1'b0);
    chk({proc_flags, dsp_flags}, {5'h15, 4'hA}, "flag ports");
    apb(1'b1, `DSPDEC_FLAGS_ADDR, 32'h00000000);
    rd(`DSPDEC_FLAGS_ADDR, 32'h00000000, 1'b0);
    apb(1'b1, `DSPDEC_CTRL_ADDR, 32'h00000000);
    run({`DSPDEC_OP_BRA, 16'h0000}, 24'h000000, 4'h1, 1'b0);
    chk(opcode, 8'h00, "decode disabled");
    summarize();
  end
endmodule : dsp_controller_instr_decode_tb_top

`default_nettype wire
